// File: rtl/fstm_pkg.sv
// Constants and types for the fail-safe trip manager
package fstm_pkg;

    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 16;
    localparam logic [3:0]  ADDR_CTRL       = 4'h0;
    localparam logic [3:0]  ADDR_STATUS     = 4'h1;
    localparam logic [3:0]  ADDR_CODE       = 4'h2;
    localparam logic [3:0]  ADDR_CMD        = 4'h3;

    localparam int          CTRL_MB_EN      = 0;
    localparam int          CTRL_TS_EN      = 1;
    localparam int          CTRL_LOG_EN     = 2;
    localparam int          CTRL_METH_LSB   = 3;
    localparam int          CTRL_W          = 5;
    localparam logic [4:0]  CTRL_RST        = 5'h01;

    localparam int          CMD_BUS_RESET   = 0;

    localparam int          ST_MB_LAT       = 0;
    localparam int          ST_TS_LAT       = 1;
    localparam int          ST_LOG_LAT      = 2;
    localparam int          ST_LOG_SUSP     = 3;

    // Control methods: which party may clear a latched trip
    localparam logic [1:0]  METH_DIGITAL    = 2'h0;
    localparam logic [1:0]  METH_PANEL      = 2'h1;
    localparam logic [1:0]  METH_BUS        = 2'h2;

    // --------------------------------------------------------------
    // Trip codes
    // --------------------------------------------------------------
    localparam int          CODE_W          = 12;
    typedef logic [CODE_W-1:0] fstm_code_t;

    localparam fstm_code_t  CODE_NONE       = 12'h000;
    localparam fstm_code_t  MB_CODE_MIN     = 12'h962;
    localparam fstm_code_t  MB_CODE_MAX     = 12'h984;
    localparam int          MB_SEL_W        = 4;
    localparam logic [3:0]  MB_SEL_MAX      = 4'he;
    localparam fstm_code_t  TS_CODE_BASE    = 12'h9c5;
    localparam fstm_code_t  TS_CODE_MAX     = 12'ha15;
    localparam fstm_code_t  TS_REMOTE_OFS   = 12'h032;
    localparam int          TS_IDX_W        = 5;
    localparam logic [4:0]  TS_IDX_MAX      = 5'h1e;
    localparam fstm_code_t  LOG_CODE_BASE   = 12'ha29;
    localparam fstm_code_t  LOG_CODE_MAX    = 12'ha2b;
    localparam int          LOG_KINDS       = 3;
    localparam int          LOG_FAIL_LIMIT  = 20;

    // Touchscreen fault report
    typedef struct packed {
        logic                   valid;
        logic                   remote;
        logic [TS_IDX_W-1:0]    idx;
    } fstm_ts_fault_t;

    // Main-board fault report
    typedef struct packed {
        logic                   valid;
        logic [MB_SEL_W-1:0]    sel;
    } fstm_mb_fault_t;

endpackage

// File: rtl/fstm_fail_cnt.sv
// Consecutive-failure counter for one logging activity
`timescale 1ns/1ps
`default_nettype none
module fstm_fail_cnt #(
    parameter int LIMIT = 20
) (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rst_b,
    // Attempt results
    input  wire logic i_fail,
    input  wire logic i_ok,
    // Threshold reached
    output logic      o_hit
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          hit_q;
    logic          hit_d;

    // A success breaks the run; a full run restarts the count
    always_comb begin
        cnt_d = cnt_q;
        hit_d = 1'b0;
        if (i_ok) begin
            cnt_d = '0;
        end else if (i_fail) begin
            if (cnt_q == LAST) begin
                cnt_d = '0;
                hit_d = 1'b1;
            end else begin
                cnt_d = cnt_q + CW'(1);
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= '0;
            hit_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            hit_q <= hit_d;
        end
    end

    assign o_hit = hit_q;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    a_hit_after_run: assert property (o_hit |-> $past(cnt_q) == LAST && $past(i_fail))
        else $error("Hit without a full run of failures");
endmodule
`default_nettype wire

// File: rtl/fstm_top.sv
// Fail-safe trip manager: latches, codes and reset paths
`timescale 1ns/1ps
`default_nettype none
module fstm_top
    import fstm_pkg::*;
#(
    parameter int FAIL_LIMIT = fstm_pkg::LOG_FAIL_LIMIT
) (
    // Clock and reset
    input  wire logic                         i_sys_clk,
    input  wire logic                         i_rst_b,
    // Register port
    input  wire logic [fstm_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [fstm_pkg::DATA_W-1:0]  i_wdata,
    input  wire logic                         i_wr,
    input  wire logic                         i_rd,
    output logic      [fstm_pkg::DATA_W-1:0]  o_rdata,
    // Fault reports
    input  wire fstm_pkg::fstm_mb_fault_t     i_mb_fault,
    input  wire fstm_pkg::fstm_ts_fault_t     i_ts_fault,
    input  wire logic [fstm_pkg::LOG_KINDS-1:0] i_log_fail,
    input  wire logic [fstm_pkg::LOG_KINDS-1:0] i_log_ok,
    // Reset sources
    input  wire logic                         i_dig_reset,
    input  wire logic                         i_panel_reset,
    input  wire logic                         i_supply_restored,
    // Status out
    output fstm_pkg::fstm_code_t              o_trip_code,
    output logic                              o_start_inhibit,
    output logic                              o_ts_autorecover,
    output logic                              o_log_suspended
);
    import fstm_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic fstm_code_t mb_code(input logic [MB_SEL_W-1:0] sel);
        case (sel)
            4'h0:    mb_code = 12'h962;
            4'h1:    mb_code = 12'h964;
            4'h2:    mb_code = 12'h966;
            4'h3:    mb_code = 12'h968;
            4'h4:    mb_code = 12'h96a;
            4'h5:    mb_code = 12'h96c;
            4'h6:    mb_code = 12'h974;
            4'h7:    mb_code = 12'h976;
            4'h8:    mb_code = 12'h978;
            4'h9:    mb_code = 12'h97a;
            4'ha:    mb_code = 12'h97c;
            4'hb:    mb_code = 12'h97e;
            4'hc:    mb_code = 12'h980;
            4'hd:    mb_code = 12'h982;
            default: mb_code = 12'h984;
        endcase
    endfunction

    function automatic fstm_code_t ts_code(input fstm_ts_fault_t f);
        ts_code = TS_CODE_BASE + CODE_W'(f.idx) + (f.remote ? TS_REMOTE_OFS : CODE_NONE);
    endfunction

    function automatic logic path_reset(input logic [1:0] meth, input logic dig,
                                        input logic panel, input logic bus);
        if (meth == METH_DIGITAL) begin
            path_reset = dig;
        end else if (meth == METH_PANEL) begin
            path_reset = panel;
        end else if (meth == METH_BUS) begin
            path_reset = bus;
        end else begin
            path_reset = 1'b0;
        end
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Reset input and supply monitor are asynchronous pins
    logic [2:0] dig_sync_q;
    logic [2:0] sup_sync_q;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dig_sync_q <= 3'h0;
            sup_sync_q <= 3'h0;
        end else begin
            dig_sync_q <= {dig_sync_q[1:0], i_dig_reset};
            sup_sync_q <= {sup_sync_q[1:0], i_supply_restored};
        end
    end

    logic dig_edge;
    logic sup_edge;
    assign dig_edge = dig_sync_q[1] && !dig_sync_q[2];
    assign sup_edge = sup_sync_q[1] && !sup_sync_q[2];

    // ------------------------------------------------------------
    // Logging failure counters
    // ------------------------------------------------------------
    logic [LOG_KINDS-1:0] log_hit;

    for (genvar k = 0; k < LOG_KINDS; k++) begin : g_log
        fstm_fail_cnt #(
            .LIMIT (FAIL_LIMIT)
        ) u_cnt (
            .i_sys_clk (i_sys_clk),
            .i_rst_b   (i_rst_b),
            .i_fail    (i_log_fail[k]),
            .i_ok      (i_log_ok[k]),
            .o_hit     (log_hit[k])
        );
    end

    // ------------------------------------------------------------
    // Registers and trip latches
    // ------------------------------------------------------------
    logic [CTRL_W-1:0]  ctrl_q,    ctrl_d;
    logic               mb_lat_q,  mb_lat_d;
    logic               ts_lat_q,  ts_lat_d;
    logic               log_lat_q, log_lat_d;
    logic               susp_q,    susp_d;
    logic               recov_q,   recov_d;
    logic               inhib_q,   inhib_d;
    fstm_code_t         mb_q,      mb_d;
    fstm_code_t         ts_q,      ts_d;
    fstm_code_t         log_q,     log_d;
    fstm_code_t         code_q,    code_d;
    logic [DATA_W-1:0]  rdata_q,   rdata_d;
    logic               bus_rst;
    logic               rst_ok;
    logic               mb_set;
    logic               ts_set;
    logic               log_set;
    fstm_code_t         log_new;

    always_comb begin
        ctrl_d   = ctrl_q;
        mb_lat_d = mb_lat_q;
        ts_lat_d = ts_lat_q;
        log_lat_d = log_lat_q;
        mb_d     = mb_q;
        ts_d     = ts_q;
        log_d    = log_q;
        susp_d   = susp_q;
        recov_d  = 1'b0;
        rdata_d  = '0;
        bus_rst  = 1'b0;
        log_new  = LOG_CODE_MAX;

        if (i_wr && i_addr == ADDR_CTRL) begin
            ctrl_d = i_wdata[CTRL_W-1:0];
        end else if (i_wr && i_addr == ADDR_CMD) begin
            bus_rst = i_wdata[CMD_BUS_RESET];
        end

        rst_ok = path_reset(ctrl_q[CTRL_METH_LSB +: 2], dig_edge, i_panel_reset, bus_rst);

        // Clearing first, so a fault in the same cycle wins
        if (rst_ok) begin
            mb_lat_d = 1'b0;
            ts_lat_d = 1'b0;
            log_lat_d = 1'b0;
        end
        // Supply return leaves the main-board latch alone
        if (sup_edge) begin
            ts_lat_d = 1'b0;
            log_lat_d = 1'b0;
        end

        mb_set = i_mb_fault.valid && (i_mb_fault.sel <= MB_SEL_MAX)
                 && ctrl_q[CTRL_MB_EN] && (!mb_lat_q || rst_ok);
        if (mb_set) begin
            mb_lat_d = 1'b1;
            mb_d     = mb_code(i_mb_fault.sel);
        end

        ts_set = i_ts_fault.valid && (i_ts_fault.idx <= TS_IDX_MAX)
                 && (!ts_lat_q || rst_ok || sup_edge);
        if (ts_set && ctrl_q[CTRL_TS_EN]) begin
            ts_lat_d = 1'b1;
            ts_d     = ts_code(i_ts_fault);
        end else if (ts_set) begin
            recov_d = 1'b1;
        end

        // Lowest failing activity decides the logging code
        for (int k = LOG_KINDS - 1; k >= 0; k--) begin
            if (log_hit[k]) begin
                log_new = LOG_CODE_BASE + CODE_W'(k);
            end
        end
        log_set = (|log_hit) && (!log_lat_q || rst_ok || sup_edge);
        if (log_set && ctrl_q[CTRL_LOG_EN]) begin
            log_lat_d = 1'b1;
            log_d     = log_new;
        end else if (|i_log_ok) begin
            susp_d = 1'b0;
        end
        if (|log_hit && !ctrl_q[CTRL_LOG_EN]) begin
            susp_d = 1'b1;
        end

        // Main board outranks touchscreen, touchscreen outranks logging
        if (mb_lat_d) begin
            code_d = mb_d;
        end else if (ts_lat_d) begin
            code_d = ts_d;
        end else if (log_lat_d) begin
            code_d = log_d;
        end else begin
            code_d = CODE_NONE;
        end
        inhib_d = mb_lat_d || ts_lat_d || log_lat_d;

        if (i_rd && i_addr == ADDR_CTRL) begin
            rdata_d = DATA_W'(ctrl_q);
        end else if (i_rd && i_addr == ADDR_STATUS) begin
            rdata_d = DATA_W'({susp_q, log_lat_q, ts_lat_q, mb_lat_q});
        end else if (i_rd && i_addr == ADDR_CODE) begin
            rdata_d = DATA_W'(code_q);
        end else begin
            rdata_d = '0;
        end
    end

    // Async reset models a controller reset; supply cycling is sup_edge
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_q    <= CTRL_RST;
            mb_lat_q  <= 1'b0;
            ts_lat_q  <= 1'b0;
            log_lat_q <= 1'b0;
            mb_q      <= CODE_NONE;
            ts_q      <= CODE_NONE;
            log_q     <= CODE_NONE;
            code_q    <= CODE_NONE;
            susp_q    <= 1'b0;
            recov_q   <= 1'b0;
            inhib_q   <= 1'b0;
            rdata_q   <= '0;
        end else begin
            ctrl_q    <= ctrl_d;
            mb_lat_q  <= mb_lat_d;
            ts_lat_q  <= ts_lat_d;
            log_lat_q <= log_lat_d;
            mb_q      <= mb_d;
            ts_q      <= ts_d;
            log_q     <= log_d;
            code_q    <= code_d;
            susp_q    <= susp_d;
            recov_q   <= recov_d;
            inhib_q   <= inhib_d;
            rdata_q   <= rdata_d;
        end
    end

    assign o_rdata          = rdata_q;
    assign o_trip_code      = code_q;
    assign o_start_inhibit  = inhib_q;
    assign o_ts_autorecover = recov_q;
    assign o_log_suspended  = susp_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_mb_fault_taken;
        mb_set ##1 mb_lat_q;
    endsequence

    a_mb_code_range: assert property (mb_lat_q |-> mb_q >= MB_CODE_MIN && mb_q <= MB_CODE_MAX)
        else $error("Main-board code out of range");
    a_mb_enable_gate: assert property (i_mb_fault.valid && !ctrl_q[CTRL_MB_EN] && !mb_lat_q
                                       |=> !mb_lat_q)
        else $error("Main-board trip latched while disabled");
    a_mb_clear_path: assert property ($fell(mb_lat_q) |-> $past(rst_ok))
        else $error("Main-board trip cleared without valid reset");
    a_mb_supply_hold: assert property (mb_lat_q && sup_edge && !rst_ok |=> mb_lat_q)
        else $error("Supply cycling cleared main-board trip");
    a_mb_code_table: assert property (s_mb_fault_taken |-> mb_q == mb_code($past(i_mb_fault.sel)))
        else $error("Main-board code mismatch");
    a_ts_code_range: assert property (ts_lat_q |-> ts_q >= TS_CODE_BASE && ts_q <= TS_CODE_MAX)
        else $error("Touchscreen code out of range");
    a_ts_recover: assert property (ts_set && !ctrl_q[CTRL_TS_EN] |=> o_ts_autorecover && !ts_lat_q)
        else $error("Disabled touchscreen fault not recovered");
    a_ts_supply_clear: assert property (ts_lat_q && sup_edge && !ts_set |=> !ts_lat_q)
        else $error("Supply cycling did not clear touchscreen trip");
    a_ts_remote_ofs: assert property (ts_set && ctrl_q[CTRL_TS_EN] && i_ts_fault.remote
                                      |=> ts_q == TS_CODE_BASE + TS_REMOTE_OFS
                                          + CODE_W'($past(i_ts_fault.idx)))
        else $error("Remote touchscreen code wrong");
    a_log_code_range: assert property (log_lat_q |-> log_q >= LOG_CODE_BASE && log_q <= LOG_CODE_MAX)
        else $error("Logging code out of range");
    a_log_suspend: assert property (|log_hit && !ctrl_q[CTRL_LOG_EN]
                                    |=> o_log_suspended && log_q == $past(log_q))
        else $error("Logging not suspended");
    a_log_supply_clear: assert property (log_lat_q && sup_edge && !log_set |=> !log_lat_q)
        else $error("Supply cycling did not clear logging trip");
    a_inhibit_code: assert property (o_start_inhibit |-> o_trip_code != CODE_NONE)
        else $error("Start inhibited without a trip code");
    a_inhibit_hold: assert property (mb_lat_q && !rst_ok |=> o_start_inhibit && mb_lat_q)
        else $error("Start inhibit dropped while latched");
endmodule
`default_nettype wire

// File: testbench/fstm_far_model.sv
// Far-side model: reset pin, operator panel and control supply
`timescale 1ns/1ps
`default_nettype none
module fstm_far_model (
    // Clock and requests from the bench
    input  wire logic i_sys_clk,
    input  wire logic i_req_dig,
    input  wire logic i_req_panel,
    input  wire logic i_req_supply,
    input  wire logic i_slow,
    // Lines into the block
    output logic      o_dig_reset,
    output logic      o_panel_reset,
    output logic      o_supply_restored
);
    int dig_cnt = 0;
    int sup_cnt = 0;

    // Pin held four cycles so the two-stage synchroniser sees it
    always @(posedge i_sys_clk) begin
        o_panel_reset <= i_req_panel;
        if (i_req_dig) begin
            dig_cnt <= i_slow ? 9 : 5;
        end else if (dig_cnt > 0) begin
            dig_cnt <= dig_cnt - 1;
        end
        o_dig_reset <= (dig_cnt > 0) && (dig_cnt <= 4);
        if (i_req_supply) begin
            sup_cnt <= 4;
        end else if (sup_cnt > 0) begin
            sup_cnt <= sup_cnt - 1;
        end
        o_supply_restored <= (sup_cnt > 0);
    end
endmodule
`default_nettype wire

// File: testbench/test_fstm_top.sv
// Self-checking bench for the fail-safe trip manager
`timescale 1ns/1ps
`default_nettype none
module test_fstm_top;
    import fstm_pkg::*;
    localparam int LIM = 3;

    logic           sys_clk;
    logic           rst_b;
    logic           wr;
    logic           rd;
    logic           rd_seen = 1'b0;
    logic [3:0]     addr;
    logic [15:0]    wdata;
    logic [15:0]    rdata;
    fstm_mb_fault_t mb;
    fstm_ts_fault_t ts;
    logic [2:0]     lfail;
    logic [2:0]     lok;
    logic [2:0]     rq;
    logic           slow;
    logic           dig;
    logic           panel;
    logic           sup;
    fstm_code_t     code;
    logic           inhib;
    logic           ts_auto;
    logic           log_susp;
    logic [15:0]    exp_q[$];
    int             n_mismatch = 0;
    int             checks = 0;
    int             cyc = 0;
    int             n_auto = 0;
    int             idx;
    int             m;
    int mb_tab[15] = '{2402, 2404, 2406, 2408, 2410, 2412, 2420, 2422,
                       2424, 2426, 2428, 2430, 2432, 2434, 2436};

    fstm_top #(.FAIL_LIMIT(LIM)) dut (
        .i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_mb_fault(mb), .i_ts_fault(ts), .i_log_fail(lfail),
        .i_log_ok(lok), .i_dig_reset(dig), .i_panel_reset(panel),
        .i_supply_restored(sup), .o_trip_code(code),
        .o_start_inhibit(inhib), .o_ts_autorecover(ts_auto),
        .o_log_suspended(log_susp)
    );

    fstm_far_model far_side (
        .i_sys_clk(sys_clk), .i_req_dig(rq[0]), .i_req_panel(rq[1]),
        .i_req_supply(rq[2]), .i_slow(slow), .o_dig_reset(dig),
        .o_panel_reset(panel), .o_supply_restored(sup)
    );

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------
    // Checking
    // ----------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge sys_clk) begin
        rd_seen <= rd;
        cyc++;
        if (ts_auto === 1'b1) begin
            n_auto++;
        end
        if (cyc == 10000) begin
            n_mismatch++;
            test_done();
        end
    end

    always @(negedge sys_clk) begin
        if (rd_seen) begin
            chk("rdata", rdata, exp_q.pop_front());
        end
    end

    // ----------------------------------------------------------
    // Drivers
    // ----------------------------------------------------------
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge sys_clk);
        rd <= 1'b0;
    endtask

    task automatic pulse_mb(input logic [3:0] s);
        @(posedge sys_clk);
        mb <= '{valid: 1'b1, sel: s};
        @(posedge sys_clk);
        mb <= '0;
    endtask

    task automatic pulse_ts(input logic r, input logic [4:0] x);
        @(posedge sys_clk);
        ts <= '{valid: 1'b1, remote: r, idx: x};
        @(posedge sys_clk);
        ts <= '0;
    endtask

    task automatic logp(input int k, input int n, input logic ok);
        repeat (n) begin
            @(posedge sys_clk);
            lfail <= ok ? 3'h0 : 3'(1 << k);
            lok <= ok ? 3'(1 << k) : 3'h0;
            @(posedge sys_clk);
            lfail <= 3'h0;
            lok <= 3'h0;
        end
    endtask

    // Bit 0 digital pin, bit 1 panel, bit 2 supply return
    task automatic far(input logic [2:0] v);
        @(posedge sys_clk);
        rq <= v;
        @(posedge sys_clk);
        rq <= 3'h0;
        repeat (14) @(posedge sys_clk);
    endtask

    task automatic chk_st(input logic [15:0] c, input logic [15:0] st);
        rd_reg(ADDR_CODE, c);
        rd_reg(ADDR_STATUS, st);
        #1;
        chk("trip_code", 16'(code), c);
        chk("inhibit", 16'(inhib), 16'(st[2:0] != 3'h0));
    endtask

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        void'($urandom(32'h684c6179));
        rst_b = 1'b0;
        {wr, rd, slow, addr, wdata, lfail, lok, rq} = '0;
        mb = '0;
        ts = '0;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd_reg(ADDR_CTRL, 16'h0001);
        rd_reg(4'h7, 16'h0000);
        rd_reg(ADDR_CMD, 16'h0000);
        // Upper control bits ignored; method 3 lets no path clear
        wr_reg(ADDR_CTRL, 16'hffff);
        rd_reg(ADDR_CTRL, 16'h001f);
        pulse_mb(4'hf);
        pulse_mb(4'h0);
        wr_reg(ADDR_CMD, 16'h0001);
        far(3'b011);
        chk_st(16'h0962, 16'h0001);
        wr_reg(ADDR_CTRL, 16'h0011);
        wr_reg(ADDR_CMD, 16'h0001);
        chk_st(16'h0, 16'h0);
        // Every main code, each method, wrong paths and supply first
        for (int i = 0; i < 15; i++) begin
            m = i % 3;
            wr_reg(ADDR_CTRL, 16'(1 + 8 * m));
            pulse_mb(4'(i));
            pulse_mb(4'(14 - i));
            chk_st(16'(mb_tab[i]), 16'h0001);
            if (m != 2) wr_reg(ADDR_CMD, 16'h0001);
            far(m == 0 ? 3'b110 : 3'b101);
            chk_st(16'(mb_tab[i]), 16'h0001);
            if (m == 2) wr_reg(ADDR_CMD, 16'h0001);
            else far(m == 0 ? 3'b001 : 3'b010);
            chk_st(16'h0, 16'h0);
        end
        wr_reg(ADDR_CTRL, 16'h0000);
        pulse_mb(4'h0);
        chk_st(16'h0, 16'h0);
        // Touchscreen codes, local and remote
        wr_reg(ADDR_CTRL, 16'h0003);
        for (int i = 0; i < 6; i++) begin
            idx = (i < 3) ? 28 + i : int'($urandom_range(30));
            pulse_ts(i[0], 5'(idx));
            chk_st(16'(2501 + idx + 50 * i[0]), 16'h0002);
            slow <= i[1];
            far(i[0] ? 3'b100 : 3'b001);
            chk_st(16'h0, 16'h0);
        end
        wr_reg(ADDR_CTRL, 16'h0001);
        pulse_ts(1'b0, 5'h03);
        chk_st(16'h0, 16'h0);
        chk("autorecover", 16'(n_auto), 16'h0001);
        // Logging: broken run, then full run, bus method
        wr_reg(ADDR_CTRL, 16'h0015);
        for (int k = 0; k < 3; k++) begin
            logp(k, LIM - 1, 1'b0);
            logp(k, 1, 1'b1);
            logp(k, LIM - 1, 1'b0);
            chk_st(16'h0, 16'h0);
            logp(k, 1, 1'b0);
            chk_st(16'(2601 + k), 16'h0004);
            far(3'b011);
            chk_st(16'(2601 + k), 16'h0004);
            if (k == 2) far(3'b100);
            else wr_reg(ADDR_CMD, 16'h0001);
            chk_st(16'h0, 16'h0);
        end
        // Logging trip off: suspend instead of trip
        wr_reg(ADDR_CTRL, 16'h0001);
        logp(1, LIM, 1'b0);
        chk_st(16'h0, 16'h0008);
        chk("suspended", 16'(log_susp), 16'h0001);
        logp(1, 1, 1'b1);
        chk_st(16'h0, 16'h0);
        test_done();
    end
endmodule
`default_nettype wire
